// file: pkg/test_io_immediate_pkg.sv
package test_io_immediate_pkg;

  // Instruction encoding.
  localparam logic [7:0] TEST_IO_IMMEDIATE_PREFIX_OP = 8'h_ed;
  localparam logic [7:0] TEST_IO_IMMEDIATE_SECOND_OP = 8'h_74;
  localparam logic [7:0] TEST_IO_IMMEDIATE_HIGH_ADDR = 8'h_00;
  localparam logic [1:0] TEST_IO_IMMEDIATE_INSN_BYTES = 2'h_3;
  localparam logic [2:0] TEST_IO_IMMEDIATE_MACH_CYCLES = 3'h_4;

  // Flag bit positions in the flag byte.
  localparam int TEST_IO_IMMEDIATE_FLAG_C = 0;
  localparam int TEST_IO_IMMEDIATE_FLAG_N = 1;
  localparam int TEST_IO_IMMEDIATE_FLAG_PV = 2;
  localparam int TEST_IO_IMMEDIATE_FLAG_H = 4;
  localparam int TEST_IO_IMMEDIATE_FLAG_Z = 6;
  localparam int TEST_IO_IMMEDIATE_FLAG_S = 7;

  // Reset values.
  localparam logic [7:0] TEST_IO_IMMEDIATE_FLAGS_RST = 8'h_00;
  localparam logic [15:0] TEST_IO_IMMEDIATE_ADDR_RST = 16'h_0000;
  localparam logic [7:0] TEST_IO_IMMEDIATE_BYTE_RST = 8'h_00;

  // Decoder and execution states.
  typedef enum logic [2:0] {
    TEST_IO_IMMEDIATE_IDLE  = 3'b000,
    TEST_IO_IMMEDIATE_PFX   = 3'b001,
    TEST_IO_IMMEDIATE_IMM   = 3'b010,
    TEST_IO_IMMEDIATE_IORD  = 3'b011,
    TEST_IO_IMMEDIATE_FLAGS = 3'b100
  } test_io_immediate_state_t;

  // Opcode byte delivered by the fetch unit.
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } test_io_immediate_fetch_t;

  // I/O read request towards the I/O space.
  typedef struct packed {
    logic        rd;
    logic [15:0] addr;
  } test_io_immediate_io_req_t;

endpackage

// file: rtl/test_io_immediate_flag_calc.sv
`timescale 1ns/10ps
module test_io_immediate_flag_calc (
  input  wire logic [7:0] operand,
  input  wire logic [7:0] mask,
  output logic      [7:0] flags
);
  import test_io_immediate_pkg::*;

  logic [7:0] result;

  // The AND result sets the flags and is then dropped.
  assign result = operand & mask;

  // Flag byte built from the AND result.
  always_comb begin
    flags = TEST_IO_IMMEDIATE_FLAGS_RST;
    // (RULE4) Clear C and N, set H.
    flags[TEST_IO_IMMEDIATE_FLAG_C] = 1'b0;
    flags[TEST_IO_IMMEDIATE_FLAG_N] = 1'b0;
    flags[TEST_IO_IMMEDIATE_FLAG_H] = 1'b1;
    // (RULE4) Even parity sets P/V.
    flags[TEST_IO_IMMEDIATE_FLAG_PV] = ~(^result);
    // (RULE5) Zero result test.
    flags[TEST_IO_IMMEDIATE_FLAG_Z] = (result == 8'h_00);
    // (RULE6) Sign from bit 7.
    flags[TEST_IO_IMMEDIATE_FLAG_S] = result[7];
  end
endmodule

// file: rtl/test_io_immediate_exec.sv
`timescale 1ns/10ps
// Summary of operation
// (RULE1) Address is port-low register, upper byte zero.
// (RULE2) Read I/O byte, AND with immediate.
// (RULE3) Internal register hit uses internal data.
// (RULE4) Clear C,N; set H; parity to P/V.
// (RULE5) Zero flag set on zero result.
// (RULE6) Sign flag follows result bit 7.
// (RULE7) Decode ED 74 imm, four machine cycles.
// (RULE8) Result discarded; no write, registers unchanged.
module test_io_immediate_exec (
  input  wire logic                    sys_clk,
  input  wire logic                    rst_b,
  input  wire test_io_immediate_pkg::test_io_immediate_fetch_t fetch,
  input  wire logic [7:0]              port_low_reg,
  input  wire logic [7:0]              flags_in,
  output test_io_immediate_pkg::test_io_immediate_io_req_t     io_req,
  input  wire logic                    io_ack,
  input  wire logic [7:0]              ext_rdata,
  input  wire logic                    int_hit,
  input  wire logic [7:0]              int_rdata,
  output logic                         io_wr,
  output logic [7:0]                   flags_out,
  output logic                         flags_we,
  output logic                         busy,
  output logic [2:0]                   mcycle
);
  import test_io_immediate_pkg::*;

  test_io_immediate_state_t state_q;
  logic [7:0]   imm_q;
  logic [7:0]   data_q;
  logic [15:0]  addr_q;
  logic         rd_q;
  logic [7:0]   flags_q;
  logic         flags_we_q;
  logic [2:0]   mcycle_q;
  logic [7:0]   new_flags;

  // Decoder walks ED, 74, immediate, then the I/O read.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= TEST_IO_IMMEDIATE_IDLE;
    end else begin
      case (state_q)
        // (RULE7) Prefix byte match.
        TEST_IO_IMMEDIATE_IDLE: begin
          if (fetch.valid && fetch.data == TEST_IO_IMMEDIATE_PREFIX_OP) begin
            state_q <= TEST_IO_IMMEDIATE_PFX;
          end
        end
        // (RULE7) Second byte match.
        TEST_IO_IMMEDIATE_PFX: begin
          if (fetch.valid) begin
            state_q <= (fetch.data == TEST_IO_IMMEDIATE_SECOND_OP) ? TEST_IO_IMMEDIATE_IMM : TEST_IO_IMMEDIATE_IDLE;
          end
        end
        TEST_IO_IMMEDIATE_IMM: begin
          if (fetch.valid) begin
            state_q <= TEST_IO_IMMEDIATE_IORD;
          end
        end
        TEST_IO_IMMEDIATE_IORD: begin
          if (io_ack) begin
            state_q <= TEST_IO_IMMEDIATE_FLAGS;
          end
        end
        TEST_IO_IMMEDIATE_FLAGS: begin
          state_q <= TEST_IO_IMMEDIATE_IDLE;
        end
        default: begin
          state_q <= TEST_IO_IMMEDIATE_IDLE;
        end
      endcase
    end
  end

  // Machine cycle count, one per fetched byte plus the I/O read.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      mcycle_q <= 3'h_0;
    end else if (state_q == TEST_IO_IMMEDIATE_IDLE && fetch.valid && fetch.data == TEST_IO_IMMEDIATE_PREFIX_OP) begin
      mcycle_q <= 3'h_1;
    end else if ((state_q == TEST_IO_IMMEDIATE_PFX || state_q == TEST_IO_IMMEDIATE_IMM) && fetch.valid) begin
      mcycle_q <= mcycle_q + 3'h_1;
    end else if (state_q == TEST_IO_IMMEDIATE_IORD && io_ack) begin
      // (RULE7) Fourth cycle ends it.
      mcycle_q <= TEST_IO_IMMEDIATE_MACH_CYCLES;
    end else if (state_q == TEST_IO_IMMEDIATE_FLAGS) begin
      mcycle_q <= 3'h_0;
    end
  end

  // Immediate mask capture.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      imm_q <= TEST_IO_IMMEDIATE_BYTE_RST;
    end else if (state_q == TEST_IO_IMMEDIATE_IMM && fetch.valid) begin
      imm_q <= fetch.data;
    end
  end

  // I/O address and read strobe.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      addr_q <= TEST_IO_IMMEDIATE_ADDR_RST;
      rd_q   <= 1'b0;
    end else if (state_q == TEST_IO_IMMEDIATE_IMM && fetch.valid) begin
      // (RULE1) Port byte low, zero high.
      addr_q <= {TEST_IO_IMMEDIATE_HIGH_ADDR, port_low_reg};
      rd_q   <= 1'b1;
    end else if (state_q == TEST_IO_IMMEDIATE_IORD && io_ack) begin
      rd_q   <= 1'b0;
    end
  end

  // Operand capture from the selected source.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      data_q <= TEST_IO_IMMEDIATE_BYTE_RST;
    end else if (state_q == TEST_IO_IMMEDIATE_IORD && io_ack) begin
      // (RULE3) Internal register takes precedence.
      data_q <= int_hit ? int_rdata : ext_rdata;
    end
  end

  // (RULE2) AND and flag evaluation.
  test_io_immediate_flag_calc u_flag_calc (
    .operand (data_q),
    .mask    (imm_q),
    .flags   (new_flags)
  );

  // Flag write-back; the AND result itself is never stored.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      flags_q    <= TEST_IO_IMMEDIATE_FLAGS_RST;
      flags_we_q <= 1'b0;
    end else if (state_q == TEST_IO_IMMEDIATE_FLAGS) begin
      // (RULE8) Only flags are updated.
      flags_q    <= (flags_in & 8'h_28) | new_flags;
      flags_we_q <= 1'b1;
    end else begin
      flags_we_q <= 1'b0;
    end
  end

  assign io_req.addr = addr_q;
  assign io_req.rd   = rd_q;
  // (RULE8) No write cycle issued.
  assign io_wr       = 1'b0;
  assign flags_out   = flags_q;
  assign flags_we    = flags_we_q;
  assign busy        = (state_q != TEST_IO_IMMEDIATE_IDLE);
  assign mcycle      = mcycle_q;
endmodule

// file: tb/tipi_monitor.sv
`timescale 1ns/10ps
module tipi_monitor (
  input wire logic                     sys_clk,
  input wire logic                     rst_b,
  input wire test_io_immediate_pkg::test_io_immediate_fetch_t  fetch,
  input wire logic [7:0]               port_low_reg,
  input wire test_io_immediate_pkg::test_io_immediate_io_req_t io_req,
  input wire logic                     io_ack,
  input wire logic [7:0]               ext_rdata,
  input wire logic                     int_hit,
  input wire logic [7:0]               int_rdata,
  input wire logic                     io_wr,
  input wire logic [7:0]               flags_out,
  input wire logic                     flags_we,
  input wire logic                     busy
);
  import test_io_immediate_pkg::*;
  logic [7:0] imm_q;
  logic [7:0] res_q;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // Keeps the last fetched byte and the masked operand.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      imm_q <= 8'h_00;
      res_q <= 8'h_00;
    end else begin
      if (fetch.valid) imm_q <= fetch.data;
      if (io_ack && io_req.rd) res_q <= (int_hit ? int_rdata : ext_rdata) & imm_q;
    end
  end
  sequence s_hdr;
    fetch.valid && !busy && fetch.data == TEST_IO_IMMEDIATE_PREFIX_OP
    ##1 fetch.valid && fetch.data == TEST_IO_IMMEDIATE_SECOND_OP;
  endsequence
  property p_dec; s_hdr ##1 fetch.valid |=> io_req.rd; endproperty
  a_dec: assert property (p_dec) else $error("no read");
  property p_addr; io_req.rd |-> io_req.addr == {TEST_IO_IMMEDIATE_HIGH_ADDR, port_low_reg}; endproperty
  a_addr: assert property (p_addr) else $error("bad address");
  property p_we; io_ack && io_req.rd |-> ##[1:2] flags_we; endproperty
  a_we: assert property (p_we) else $error("no flag write");
  property p_fix; flags_we |-> flags_out[1:0] == 2'h_0 && flags_out[4]; endproperty
  a_fix: assert property (p_fix) else $error("bad C N H");
  property p_pv; flags_we |-> flags_out[2] == ~^res_q; endproperty
  a_pv: assert property (p_pv) else $error("bad parity");
  property p_z; flags_we |-> flags_out[6] == (res_q == 8'h_00); endproperty
  a_z: assert property (p_z) else $error("bad zero");
  property p_s; flags_we |-> flags_out[7] == res_q[7]; endproperty
  a_s: assert property (p_s) else $error("bad sign");
  property p_wr; busy |-> !io_wr; endproperty
  a_wr: assert property (p_wr) else $error("write seen");
endmodule
bind test_io_immediate_exec tipi_monitor u_mon (.*);

// file: tb/tipi_io_model.sv
`timescale 1ns/10ps
module tipi_io_model (
  input  wire logic                     sys_clk,
  input  wire logic                     slow,
  input  wire test_io_immediate_pkg::test_io_immediate_io_req_t io_req,
  output logic                          io_ack,
  output logic [7:0]                    ext_rdata,
  output logic                          int_hit,
  output logic [7:0]                    int_rdata
);
  import test_io_immediate_pkg::*;
  logic wait_q;
  // Answers a read after one cycle, or two when slow.
  always_ff @(posedge sys_clk) begin
    wait_q <= io_req.rd && !io_ack;
    io_ack <= io_req.rd && !io_ack && (!slow || wait_q);
  end
  // Ports below 8'h_40 are on-chip; data is inverted outside the answer.
  assign int_hit = io_req.addr[7:6] == 2'h_0;
  assign ext_rdata = (io_req.addr[7:0] ^ 8'h_5a) ^ {8{!io_ack}};
  assign int_rdata = (io_req.addr[7:0] ^ 8'h_c3) ^ {8{!io_ack}};
endmodule

// file: tb/test_io_port_instruction_tb_top.sv
`timescale 1ns/10ps
module test_io_port_instruction_tb_top;
  import test_io_immediate_pkg::*;
  test_io_immediate_fetch_t  fetch        = '0;
  test_io_immediate_io_req_t io_req;
  logic          sys_clk      = 1'b0;
  logic          rst_b        = 1'b0;
  logic          slow         = 1'b0;
  logic          io_ack, int_hit, io_wr, flags_we, busy;
  logic [7:0]    port_low_reg = 8'h_00;
  logic [7:0]    flags_in     = 8'h_28;
  logic [7:0]    ext_rdata, int_rdata, flags_out;
  logic [2:0]    mcycle;
  int            n_fail, samples_checked, cyc;
  logic [23:0]   rows [4]     = '{24'h_3c_0f3c, 24'h_80_80b8, 24'h_00_ffbc, 24'h_55_f07c};
  test_io_immediate_exec DUT (.*);
  tipi_io_model u_io (.*);
  // Free-running clock.
  always #4 sys_clk = ~sys_clk;
  task automatic stop_test;
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic run(input logic [7:0] op, input logic [15:0] pi, input logic [8:0] exp);
    port_low_reg = pi[15:8];
    @(negedge sys_clk) fetch = {1'b1, TEST_IO_IMMEDIATE_PREFIX_OP};
    @(negedge sys_clk) fetch = {1'b1, op};
    @(negedge sys_clk) fetch = {1'b1, pi[7:0]};
    @(negedge sys_clk) fetch = '0;
    for (int i = 0; i < 9 && flags_we !== 1'b1; i++) @(negedge sys_clk);
    chk({flags_we, exp[8] ? flags_out : 8'h_00}, exp);
    $display("test %h done", pi);
  endtask
  // Cuts a hang short.
  always @(posedge sys_clk) begin
    if (++cyc > 1000) begin
      n_fail++;
      stop_test;
    end
  end
  // Table rows, then refusal, slow answer and reset mid-run.
  initial begin
    repeat (2) @(negedge sys_clk);
    rst_b = 1'b1;
    foreach (rows[i]) run(TEST_IO_IMMEDIATE_SECOND_OP, rows[i][23:8], {1'b1, rows[i][7:0]});
    run(8'h_75, 16'h_3c0f, 9'h_000);
    slow = 1'b1;
    run(TEST_IO_IMMEDIATE_SECOND_OP, 16'h_55f0, 9'h_17c);
    @(negedge sys_clk) fetch = {1'b1, TEST_IO_IMMEDIATE_PREFIX_OP};
    @(negedge sys_clk) rst_b = 1'b0;
    fetch = '0;
    #1 chk({busy, io_req.addr[7:0]}, 9'h_000);
    @(negedge sys_clk) rst_b = 1'b1;
    run(TEST_IO_IMMEDIATE_SECOND_OP, 16'h_80ff, 9'h_1b8);
    stop_test;
  end
endmodule
